// ---- inc/stfr_params.svh ----
// Constants of the sequence timer and fault response block
// Notes on behaviour
// RL1: Six input-voltage thresholds are stored as 16-bit L11 words in volts.
// RL2: Four temperature fault and warn thresholds are stored as 16-bit L11 words.
// RL3: Turn-on delay, rise, turn-on timeout and turn-off delay are 16-bit L11 milliseconds.
// RL4: Enable waits the turn-on delay, counted on the shared timebase only.
// RL5: With connect mode 00, the DAC connects once the rise time has elapsed.
// RL6: Rise, timeout and turn-off delay use shared timebase if present, else oscillator.
// RL7: Output reaching the under-voltage limit in time unmasks it, else timeout fault.
// RL8: A zero turn-on timeout means the ramp may last forever.
// RL9: Losing the on request waits the turn-off delay, then disables the channel.
// RL10: Turn-on and turn-off delays clamp at 13.1 s; 10 us or 200 us steps.
// RL11: Rise and timeout clamp at 655 ms with 10 us steps.
// RL12: A timer read returns the word last written, unclamped and unrounded.
// RL13: A fast output fault sets status bits and pulls the alert low.
// RL14: A channel in high-resolution current mode ignores output faults.
// RL15: Action 00 keeps the channel running through a fast fault.
// RL16: Action 01 runs for the deglitch time, then shuts down and retries.
// RL17: Action 1X shuts down at once or after turn-off delay, then retries.
// RL18: Retry field 000 leaves a faulted channel disabled.
// RL19: Nonzero retry restarts up to the global count unless off, unbiased or refaulted.
// RL20: Deglitch zero trips at once, otherwise after that many supervisor samples.
// RL21: Clearing faults drops status and alert but never restarts a latched channel.
// RL22: L11 is a signed 11-bit mantissa times two to a signed 5-bit exponent.
`ifndef STFR_PARAMS_SVH
`define STFR_PARAMS_SVH

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define STFR_CMD_TON_DELAY 4'h0
`define STFR_CMD_RISE 4'h1
`define STFR_CMD_TON_MAX 4'h2
`define STFR_CMD_TOFF_DELAY 4'h3
`define STFR_CMD_OV_RESP 4'h4
`define STFR_CMD_UV_RESP 4'h5
`define STFR_CMD_LIMIT_BASE 4'h6
`define STFR_LIMIT_WORDS 10

// ---------------------------------------------------------------
// Reset values and field codes
// ---------------------------------------------------------------
`define STFR_WORD_RESET 16'h0000
`define STFR_RESP_RESET 8'h00
`define STFR_ACT_NONE 2'h0
`define STFR_ACT_DEGLITCH 2'h1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define STFR_CLK_NS 8
`define STFR_TICK_NS 10000
`define STFR_TICK_CYC (`STFR_TICK_NS / `STFR_CLK_NS)
`define STFR_SAMPLE_NS 12200
`define STFR_SAMPLE_CYC (`STFR_SAMPLE_NS / `STFR_CLK_NS)
`define STFR_TICKS_PER_MS 17'h00064
`define STFR_SHORT_MAX 21'h00FFDC
`define STFR_LONG_MAX 21'h13FD30
`define STFR_LONG_STEP 21'h000014
`define STFR_LONG_HALF 21'h00000A

`endif

// ---- inc/stfr_pkg.sv ----
// Types of the sequence timer and fault response block
package stfr_pkg;
  typedef enum logic [2:0] {
    STFR_OFF = 3'b000,
    STFR_ON_DLY = 3'b001,
    STFR_RAMP = 3'b010,
    STFR_RUN = 3'b011,
    STFR_OFF_DLY = 3'b100,
    STFR_LATCH = 3'b101
  } stfr_state_e;

  typedef struct packed {
    logic byte_vout;
    logic word_vout;
    logic vout_ov;
    logic vout_uv;
    logic ton_max;
  } stfr_status_s;

  typedef struct packed {
    logic [1:0] action;
    logic [2:0] retry;
    logic [2:0] deglitch;
  } stfr_resp_s;

  typedef logic [20:0] stfr_ticks_t;
endpackage

// ---- logic/stfr_limit_mem.sv ----
// Storage for the input-voltage and temperature limit words
`include "stfr_params.svh"
module stfr_limit_mem
  import stfr_pkg::*;
#(
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem_ff [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
    $error("limit memory depth does not fit the address");
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= `STFR_WORD_RESET;
      end
    end else if (wr_en && 32'(wr_addr) < DEPTH) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data <= `STFR_WORD_RESET;
    end else if (32'(rd_addr) < DEPTH) begin
      rd_data <= mem_ff[rd_addr];
    end else begin
      rd_data <= `STFR_WORD_RESET;
    end
  end
endmodule

// ---- logic/stfr_l11_ticks.sv ----
// Conversion of an L11 millisecond word to a count of 10 us ticks
`include "stfr_params.svh"
module stfr_l11_ticks
  import stfr_pkg::*;
(
  // Timer word and range
  input wire logic [15:0] l11,
  input wire logic long_range,
  // Clamped, rounded count
  output stfr_ticks_t ticks
);
  logic signed [10:0] mant;
  logic signed [4:0] expo;
  logic [16:0] prod;
  logic [4:0] rsh;
  logic [39:0] scaled;
  logic [39:0] lim;
  logic [39:0] clamped;
  logic [39:0] stepped;

  assign mant = l11[10:0];
  assign expo = l11[15:11];
  assign prod = 17'(l11[9:0]) * `STFR_TICKS_PER_MS;

  // Negative or zero mantissa gives no delay at all
  always_comb begin
    rsh = 5'(-expo);
    scaled = 40'h0;
    if (mant > 11'sh000) begin
      if (!expo[4]) begin
        scaled = 40'(prod) << expo[3:0]; // RL22
      end else begin
        scaled = (40'(prod) + (40'h1 << (rsh - 5'h1))) >> rsh; // RL22
      end
    end
    lim = long_range ? 40'(`STFR_LONG_MAX) : 40'(`STFR_SHORT_MAX); // RL10 RL11
    clamped = (scaled > lim) ? lim : scaled;
    stepped = clamped;
    if (long_range && clamped > 40'(`STFR_SHORT_MAX)) begin
      stepped = ((clamped + 40'(`STFR_LONG_HALF)) / 40'(`STFR_LONG_STEP))
                * 40'(`STFR_LONG_STEP); // RL10
    end
    ticks = stfr_ticks_t'(stepped);
  end
endmodule

// ---- logic/stfr_channel.sv ----
// One channel of power sequencing timers and fast fault response
`include "stfr_params.svh"
module stfr_channel
  import stfr_pkg::*;
#(
  parameter int TICK_CYC = `STFR_TICK_CYC,
  parameter int SAMPLE_CYC = `STFR_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  input wire logic clear_faults,
  // Sequencing control
  input wire logic channel_on_pin,
  input wire logic operation_on,
  input wire logic bias_ok,
  input wire logic shutdown_seq,
  input wire logic [1:0] dac_mode,
  input wire logic high_res,
  input wire logic [2:0] retry_count,
  // Timebase
  input wire logic share_clk_present,
  input wire logic share_clk_tick,
  // Fast supervisor
  input wire logic vout_ov_fast,
  input wire logic vout_uv_fast,
  // Channel outputs
  output logic vout_enable,
  output logic dac_connect,
  output logic alert_out_n,
  output stfr_status_s status
);
  localparam int T_ON = 0;
  localparam int T_RISE = 1;
  localparam int T_MAX = 2;
  localparam int T_OFF = 3;
  localparam int DIV_W = $clog2(TICK_CYC > SAMPLE_CYC ? TICK_CYC : SAMPLE_CYC);

  if (TICK_CYC < 2 || SAMPLE_CYC < 2) begin : g_chk
    $error("divider counts must be at least two cycles");
  end

  stfr_state_e state_ff;
  logic [15:0] tmr_ff [4];
  stfr_ticks_t ticks [4];
  stfr_resp_s resp_ff [2];
  stfr_ticks_t cnt_ff;
  stfr_ticks_t rise_cnt_ff;
  logic en_ff;
  logic dac_ff;
  logic alert_n_ff;
  logic fault_off_ff;
  logic [2:0] retry_left_ff;
  logic [2:0] retry_sel_ff;
  logic [2:0] dgl_cnt_ff [2];
  logic [DIV_W-1:0] div_cnt_ff [2];
  logic div_tick_ff [2];
  logic rd_pend_ff;
  logic [3:0] rd_code_ff;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  stfr_status_s status_ff;
  stfr_status_s nxt_status;
  logic [15:0] mem_rdata;
  logic [15:0] rd_word;
  logic [3:0] lim_addr;
  logic on_cmd;
  logic tmr_tick;
  logic [1:0] fault_in;
  logic [1:0] trip;
  logic trip_any;
  logic [2:0] fault_retry;
  logic can_retry;
  logic ton_max_evt;

  // ---------------------------------------------------------------
  // Command port
  // ---------------------------------------------------------------
  assign lim_addr = cmd_code - `STFR_CMD_LIMIT_BASE;

  stfr_limit_mem #(
    .DEPTH(`STFR_LIMIT_WORDS),
    .AW(4)
  ) u_limits (
    .clk(clk),
    .resetn(resetn),
    .wr_en(cmd_wr && cmd_code >= `STFR_CMD_LIMIT_BASE), // RL1 RL2
    .wr_addr(lim_addr),
    .wr_data(cmd_wdata),
    .rd_addr(lim_addr),
    .rd_data(mem_rdata)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        tmr_ff[i] <= `STFR_WORD_RESET;
      end
    end else if (cmd_wr && cmd_code[3:2] == 2'h0) begin
      tmr_ff[cmd_code[1:0]] <= cmd_wdata; // RL3
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      resp_ff[0] <= `STFR_RESP_RESET;
      resp_ff[1] <= `STFR_RESP_RESET;
    end else if (cmd_wr && (cmd_code == `STFR_CMD_OV_RESP || cmd_code == `STFR_CMD_UV_RESP)) begin
      resp_ff[cmd_code[0]] <= cmd_wdata[7:0];
    end
  end

  // Timer words read back raw; clamping lives only in the converters
  always_comb begin
    rd_word = mem_rdata;
    if (rd_code_ff[3:2] == 2'h0) begin
      rd_word = tmr_ff[rd_code_ff[1:0]]; // RL12
    end else if (rd_code_ff == `STFR_CMD_OV_RESP || rd_code_ff == `STFR_CMD_UV_RESP) begin
      rd_word = {8'h00, resp_ff[rd_code_ff[0]]};
    end
  end

  // Two-stage read: the limit memory answers one cycle after the code
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_pend_ff <= 1'b0;
      rd_code_ff <= 4'h0;
      rdata_ff <= `STFR_WORD_RESET;
      rvalid_ff <= 1'b0;
    end else begin
      rd_pend_ff <= cmd_rd;
      rd_code_ff <= cmd_code;
      rvalid_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        rdata_ff <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_conv
    stfr_l11_ticks u_conv (
      .l11(tmr_ff[i]),
      .long_range(i == T_ON || i == T_OFF),
      .ticks(ticks[i])
    );
  end

  // Entry 0 is the 10 us oscillator tick, entry 1 the supervisor sample
  for (genvar i = 0; i < 2; i++) begin : g_div
    localparam int LIMIT = (i == 0) ? TICK_CYC : SAMPLE_CYC;
    always_ff @(posedge clk) begin
      if (!resetn) begin
        div_cnt_ff[i] <= '0;
        div_tick_ff[i] <= 1'b0;
      end else if (div_cnt_ff[i] == DIV_W'(LIMIT - 1)) begin
        div_cnt_ff[i] <= '0;
        div_tick_ff[i] <= 1'b1;
      end else begin
        div_cnt_ff[i] <= div_cnt_ff[i] + DIV_W'(1);
        div_tick_ff[i] <= 1'b0;
      end
    end
  end

  assign tmr_tick = share_clk_present ? share_clk_tick : div_tick_ff[0]; // RL6

  // ---------------------------------------------------------------
  // Fast fault detection and deglitch
  // ---------------------------------------------------------------
  assign on_cmd = channel_on_pin && operation_on;
  // Under-voltage stays masked until the ramp has reached its limit
  assign fault_in[0] = vout_ov_fast && !high_res
                       && (state_ff == STFR_RAMP || state_ff == STFR_RUN); // RL14
  assign fault_in[1] = vout_uv_fast && !high_res && state_ff == STFR_RUN; // RL14

  for (genvar i = 0; i < 2; i++) begin : g_dgl
    always_ff @(posedge clk) begin
      if (!resetn) begin
        dgl_cnt_ff[i] <= 3'h0;
      end else if (!fault_in[i] || resp_ff[i].action != `STFR_ACT_DEGLITCH) begin
        dgl_cnt_ff[i] <= 3'h0;
      end else if (div_tick_ff[1] && dgl_cnt_ff[i] < resp_ff[i].deglitch) begin
        dgl_cnt_ff[i] <= dgl_cnt_ff[i] + 3'h1; // RL20
      end
    end
    assign trip[i] = fault_in[i] && (resp_ff[i].action[1] // RL15 RL17
                     || (resp_ff[i].action == `STFR_ACT_DEGLITCH
                         && dgl_cnt_ff[i] >= resp_ff[i].deglitch)); // RL16 RL20
  end

  assign trip_any = trip[0] || trip[1];
  assign fault_retry = trip[0] ? resp_ff[0].retry : resp_ff[1].retry;
  assign can_retry = retry_left_ff != 3'h0 && on_cmd && bias_ok; // RL19
  assign ton_max_evt = state_ff == STFR_RAMP && bias_ok && on_cmd && !trip_any
                       && vout_uv_fast && tmr_ff[T_MAX] != 16'h0 && cnt_ff == '0; // RL7 RL8

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= STFR_OFF;
      cnt_ff <= '0;
      en_ff <= 1'b0;
      fault_off_ff <= 1'b0;
      retry_left_ff <= 3'h0;
      retry_sel_ff <= 3'h0;
    end else begin
      case (state_ff)
        STFR_OFF: begin
          fault_off_ff <= 1'b0;
          if (on_cmd && bias_ok) begin
            state_ff <= STFR_ON_DLY;
            cnt_ff <= ticks[T_ON];
            retry_left_ff <= retry_count;
          end
        end
        STFR_ON_DLY: begin
          if (!on_cmd || !bias_ok) begin
            state_ff <= STFR_OFF;
          end else if (cnt_ff == '0) begin
            state_ff <= STFR_RAMP;
            en_ff <= 1'b1;
            cnt_ff <= ticks[T_MAX];
          end else if (share_clk_tick) begin
            cnt_ff <= cnt_ff - 21'h1; // RL4
          end
        end
        STFR_RAMP, STFR_RUN: begin
          if (!bias_ok) begin
            en_ff <= 1'b0;
            state_ff <= STFR_OFF;
          end else if (trip_any) begin
            retry_sel_ff <= fault_retry;
            fault_off_ff <= 1'b1;
            if (shutdown_seq) begin
              state_ff <= STFR_OFF_DLY; // RL17
              cnt_ff <= ticks[T_OFF];
            end else begin
              en_ff <= 1'b0; // RL17
              if (fault_retry != 3'h0 && can_retry) begin
                state_ff <= STFR_ON_DLY; // RL19
                cnt_ff <= ticks[T_ON];
                retry_left_ff <= retry_left_ff - 3'h1;
              end else begin
                state_ff <= STFR_LATCH; // RL18
              end
            end
          end else if (!on_cmd) begin
            state_ff <= STFR_OFF_DLY; // RL9
            cnt_ff <= ticks[T_OFF];
            // A plain off after a successful retry must not be taken as a fault
            fault_off_ff <= 1'b0;
          end else if (state_ff == STFR_RAMP) begin
            if (!vout_uv_fast) begin
              state_ff <= STFR_RUN; // RL7
            end else if (ton_max_evt) begin
              en_ff <= 1'b0; // RL7
              state_ff <= STFR_LATCH;
            end else if (tmr_tick && cnt_ff != '0) begin
              cnt_ff <= cnt_ff - 21'h1;
            end
          end
        end
        STFR_OFF_DLY: begin
          if (cnt_ff == '0) begin
            en_ff <= 1'b0; // RL9
            if (!fault_off_ff) begin
              state_ff <= STFR_OFF;
            end else if (retry_sel_ff != 3'h0 && can_retry) begin
              state_ff <= STFR_ON_DLY; // RL19
              cnt_ff <= ticks[T_ON];
              retry_left_ff <= retry_left_ff - 3'h1;
            end else begin
              state_ff <= STFR_LATCH; // RL18
            end
          end else if (tmr_tick) begin
            cnt_ff <= cnt_ff - 21'h1; // RL6
          end
        end
        STFR_LATCH: begin
          // Clearing faults does not restart; only an off command unlatches
          en_ff <= 1'b0;
          if (!on_cmd) begin
            state_ff <= STFR_OFF; // RL21
          end
        end
        default: begin
          en_ff <= 1'b0;
          state_ff <= STFR_OFF;
        end
      endcase
    end
  end

  // DAC soft-connect after the rise time
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rise_cnt_ff <= '0;
      dac_ff <= 1'b0;
    end else if (state_ff == STFR_ON_DLY) begin
      rise_cnt_ff <= ticks[T_RISE];
      dac_ff <= 1'b0;
    end else if (state_ff == STFR_RAMP || state_ff == STFR_RUN) begin
      if (rise_cnt_ff == '0) begin
        dac_ff <= dac_mode == 2'b00; // RL5
      end else if (tmr_tick) begin
        rise_cnt_ff <= rise_cnt_ff - 21'h1; // RL6
      end
    end else begin
      dac_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status and alert
  // ---------------------------------------------------------------
  // A fault present in the clearing cycle keeps its bit
  always_comb begin
    nxt_status.vout_ov = fault_in[0] || (status_ff.vout_ov && !clear_faults); // RL13 RL21
    nxt_status.vout_uv = fault_in[1] || (status_ff.vout_uv && !clear_faults); // RL13 RL21
    nxt_status.ton_max = ton_max_evt || (status_ff.ton_max && !clear_faults);
    nxt_status.word_vout = nxt_status.vout_ov || nxt_status.vout_uv || nxt_status.ton_max;
    nxt_status.byte_vout = nxt_status.word_vout;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_ff <= '0;
      alert_n_ff <= 1'b1;
    end else begin
      status_ff <= nxt_status;
      alert_n_ff <= !nxt_status.word_vout; // RL13
    end
  end

  assign vout_enable = en_ff;
  assign dac_connect = dac_ff;
  assign alert_out_n = alert_n_ff;
  assign status = status_ff;
  assign cmd_rdata = rdata_ff;
  assign cmd_rvalid = rvalid_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_alert_low;
    (status_ff.vout_ov || status_ff.vout_uv) |-> !alert_n_ff;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert not low with fault status"); // RL13

  property p_ov_status;
    fault_in[0] |=> status_ff.vout_ov && status_ff.byte_vout;
  endproperty
  a_ov_status: assert property (p_ov_status) else $error("ov fault did not set status"); // RL13

  property p_hires_quiet;
    (high_res && !status_ff.vout_ov && !status_ff.vout_uv)
      |=> (!status_ff.vout_ov && !status_ff.vout_uv);
  endproperty
  a_hires_quiet: assert property (p_hires_quiet) else $error("high-res channel took a fault"); // RL14

  property p_act_none;
    (state_ff == STFR_RUN && on_cmd && bias_ok && resp_ff[0].action == 2'h0
      && resp_ff[1].action == 2'h0) |=> state_ff == STFR_RUN && en_ff;
  endproperty
  a_act_none: assert property (p_act_none) else $error("action 00 interrupted channel"); // RL15

  property p_hard_off;
    (state_ff == STFR_RUN && bias_ok && fault_in[0] && resp_ff[0].action[1] && !shutdown_seq)
      |=> !en_ff;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("action 1X did not shut down"); // RL17

  property p_dgl_count;
    (state_ff == STFR_RUN && bias_ok && fault_in[0] && resp_ff[0].action == 2'h1
      && dgl_cnt_ff[0] == resp_ff[0].deglitch && !shutdown_seq) |=> !en_ff;
  endproperty
  a_dgl_count: assert property (p_dgl_count) else $error("deglitched fault did not shut down"); // RL16

  property p_dgl_wait;
    (fault_in[0] && resp_ff[0].action == 2'h1 && resp_ff[0].deglitch != 3'h0
      && dgl_cnt_ff[0] == 3'h0) |-> !trip[0];
  endproperty
  a_dgl_wait: assert property (p_dgl_wait) else $error("fault tripped before deglitch"); // RL20

  property p_latch_hold;
    (state_ff == STFR_LATCH && on_cmd) |=> state_ff == STFR_LATCH && !en_ff;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched channel restarted"); // RL18

  property p_clear_set_wins;
    (clear_faults && fault_in[1]) |=> status_ff.vout_uv && !alert_n_ff;
  endproperty
  a_clear_set_wins: assert property (p_clear_set_wins) else $error("uv fault lost on clear"); // RL21

  property p_on_wait;
    (state_ff == STFR_ON_DLY && on_cmd && bias_ok && cnt_ff != '0 && !share_clk_tick)
      |=> state_ff == STFR_ON_DLY && $stable(cnt_ff) && !en_ff;
  endproperty
  a_on_wait: assert property (p_on_wait) else $error("turn-on delay moved without share tick"); // RL4

  property p_no_limit;
    (state_ff == STFR_RAMP && tmr_ff[T_MAX] == 16'h0 && on_cmd && bias_ok
      && vout_uv_fast && !trip_any) |=> state_ff == STFR_RAMP && !status_ff.ton_max;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("zero timeout ended the ramp"); // RL8

  property p_dac_mode;
    (dac_mode != 2'b00) |=> !dac_ff;
  endproperty
  a_dac_mode: assert property (p_dac_mode) else $error("dac connected in wrong mode"); // RL5

  c_reach_run: cover property (state_ff == STFR_RAMP ##1 state_ff == STFR_RUN);
  c_ton_max: cover property (ton_max_evt ##1 state_ff == STFR_LATCH);
  c_retry: cover property (state_ff == STFR_OFF_DLY ##1 state_ff == STFR_ON_DLY);
  c_seq_off: cover property (state_ff == STFR_OFF_DLY ##1 state_ff == STFR_OFF);
endmodule

// ---- bench/stfr_conv_model.sv ----
// Converter model: output ramps after enable, may stick low or be forced high
module stfr_conv_model
#(
  parameter int RAMP = 6
) (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic stuck,
  input wire logic ov_force,
  // Converter side
  input wire logic vout_enable,
  output logic vout_ov_fast,
  output logic vout_uv_fast
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // A disabled converter has no output, so it reads under limit and never over
  always @(posedge clk) cnt <= vout_enable ? cnt + 1 : 0;
  assign vout_uv_fast = stuck || cnt < RAMP;
  assign vout_ov_fast = ov_force && vout_enable;
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for one sequencing and fast fault channel
module testbench
  import stfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, cmd_wr, cmd_rd, clear_faults, pin, high_res, tick, ov_force, stuck;
  logic [3:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, got;
  logic [15:0] mem [16];
  logic [1:0] tcnt, dmode;
  logic [2:0] rcnt;
  logic share, seq;
  logic cmd_rvalid, vout_enable, dac_connect, alert_out_n, ov, uv;
  stfr_status_s status;
  int err_count = 0;
  int n_tests = 0;

  stfr_channel #(.TICK_CYC(4), .SAMPLE_CYC(5)) u_stfr_channel (
    .clk(clk), .resetn(resetn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .clear_faults(clear_faults), .channel_on_pin(pin), .operation_on(1'b1), .bias_ok(1'b1),
    .shutdown_seq(seq), .dac_mode(dmode), .high_res(high_res), .retry_count(rcnt),
    .share_clk_present(share), .share_clk_tick(tick), .vout_ov_fast(ov), .vout_uv_fast(uv),
    .vout_enable(vout_enable), .dac_connect(dac_connect), .alert_out_n(alert_out_n),
    .status(status));
  stfr_conv_model u_stfr_conv_model (.clk(clk), .stuck(stuck), .ov_force(ov_force),
    .vout_enable(vout_enable), .vout_ov_fast(ov), .vout_uv_fast(uv));

  always #4 clk = ~clk;
  // Shared timebase ticks once every four cycles, like the shortened divider
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] c, output logic [15:0] d);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= c;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cyc(1);
    chk(16'(cmd_rvalid), 16'h0001);
    d = cmd_rdata;
  endtask
  task automatic wait_en();
    int k;
    k = 0;
    while (vout_enable !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    chk(16'(vout_enable), 16'h0001);
  endtask
  task automatic pulse_clear();
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    cyc(2);
  endtask
  task automatic rest(input string s);
    @(posedge clk);
    pin <= 1'b0;
    ov_force <= 1'b0;
    stuck <= 1'b0;
    cyc(3);
    pulse_clear();
    $display("test %s done", s);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Response bytes keep only their low byte
  function automatic logic [15:0] exp_rd(input logic [3:0] c, input logic [15:0] d);
    return (c == 4'h4 || c == 4'h5) ? {8'h00, d[7:0]} : d;
  endfunction

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    tcnt = 2'h0;
    cmd_code = 4'h0;
    cmd_wdata = 16'h0000;
    {cmd_wr, cmd_rd, clear_faults, pin, high_res, tick, ov_force, stuck} = 8'h00;
    {share, seq, rcnt, dmode} = 7'h00;
    void'($urandom(17));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    cyc(1);
    chk(16'({alert_out_n, vout_enable, dac_connect, status}), 16'h0080);
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'($urandom());
      wr(4'(i), mem[i]);
    end
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), got);
      chk(got, exp_rd(4'(i), mem[i]));
    end
    $display("test regs done");
    wr(4'h0, 16'hC00D);
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'hC00D);
    wr(4'h3, 16'h0000);
    wr(4'h4, 16'h0080);
    wr(4'h5, 16'h0000);
    @(posedge clk);
    pin <= 1'b1;
    cyc(10);
    chk(16'(vout_enable), 16'h0000);
    wait_en();
    cyc(20);
    chk(16'({dac_connect, status.ton_max}), 16'h0002);
    @(posedge clk);
    ov_force <= 1'b1;
    cyc(3);
    chk(16'({status[4:2], alert_out_n, vout_enable}), 16'h001C);
    @(posedge clk);
    ov_force <= 1'b0;
    cyc(5);
    chk(16'(vout_enable), 16'h0000);
    pulse_clear();
    chk(16'({status, alert_out_n, vout_enable}), 16'h0002);
    rest("ov_latch");
    @(posedge clk);
    stuck <= 1'b1;
    pin <= 1'b1;
    cyc(80);
    chk(16'({status.ton_max, alert_out_n, vout_enable}), 16'h0004);
    rest("timeout");
    wr(4'h2, 16'h0000);
    @(posedge clk);
    stuck <= 1'b1;
    pin <= 1'b1;
    cyc(100);
    chk(16'({status.ton_max, vout_enable}), 16'h0001);
    @(posedge clk);
    stuck <= 1'b0;
    high_res <= 1'b1;
    ov_force <= 1'b1;
    cyc(20);
    chk(16'({status.vout_ov, alert_out_n, vout_enable}), 16'h0003);
    wr(4'h4, 16'h0000);
    @(posedge clk);
    high_res <= 1'b0;
    stuck <= 1'b1;
    cyc(6);
    chk(16'({status.vout_ov, alert_out_n, vout_enable}), 16'h0005);
    pulse_clear();
    chk(16'({status.vout_ov, status.vout_uv, alert_out_n, vout_enable}), 16'h000D);
    @(posedge clk);
    ov_force <= 1'b0;
    stuck <= 1'b0;
    wr(4'h4, 16'h0043);
    @(posedge clk);
    ov_force <= 1'b1;
    cyc(8);
    chk(16'(vout_enable), 16'h0001);
    cyc(15);
    chk(16'(vout_enable), 16'h0000);
    rest("fault_actions");
    wr(4'h3, 16'hC00D);
    @(posedge clk);
    pin <= 1'b1;
    wait_en();
    cyc(20);
    @(posedge clk);
    pin <= 1'b0;
    cyc(8);
    chk(16'(vout_enable), 16'h0001);
    cyc(30);
    chk(16'(vout_enable), 16'h0000);
    $display("test turn_off done");
    @(posedge clk);
    share <= 1'b1;
    seq <= 1'b1;
    rcnt <= 3'h1;
    dmode <= 2'h1;
    wr(4'h4, 16'h0088);
    @(posedge clk);
    pin <= 1'b1;
    wait_en();
    cyc(20);
    chk(16'({dac_connect, vout_enable}), 16'h0001);
    @(posedge clk);
    ov_force <= 1'b1;
    cyc(8);
    chk(16'(vout_enable), 16'h0001);
    cyc(22);
    chk(16'(vout_enable), 16'h0000);
    wait_en();
    cyc(40);
    chk(16'({status.vout_ov, vout_enable}), 16'h0002);
    rest("retry");
    close_out();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
